// ### design/gray_defines.svh
// Functional notes
// - command word is 16 bits; code in bits 15..8, data operand in bits 7..0.
// - code 3Ah loads third even gray duration; resets to 02h.
// - stored duration v lasts v+1 gray-clock periods, 1 up to 256.
// - code 3Bh loads second even gray duration; resets to 01h.
// - code 3Ch loads first even gray duration; resets to 00h.
// - code F1h data bit 0 enters (1) or leaves (0) sleep; resets 0.
// - code F2h starts software reset; its data bits are ignored.
// - within 200 ns of software reset, oscillator runs and commands are accepted.
// - after software reset step-up stays off, column and row drivers at ground.
// - after software reset gray clock pin follows, external sync/row outputs low.
// - software reset returns all command-loaded registers to their defaults.
`ifndef GRAY_DEFINES_SVH
`define GRAY_DEFINES_SVH

`define CMD_CODE_MSB        15
`define CMD_CODE_LSB        8
`define CMD_DATA_MSB        7
`define CMD_DATA_LSB        0

`define CMD_EVEN_GRAY_LEVEL_THREE_TIME           8'h3a
`define CMD_EVEN_GRAY_LEVEL_TWO_TIME           8'h3b
`define CMD_EVEN_GRAY_LEVEL_ONE_TIME           8'h3c
`define CMD_SLEEP           8'hf1
`define CMD_SOFT_RESET      8'hf2

`define RST_EVEN_GRAY_LEVEL_THREE_TIME           8'h02
`define RST_EVEN_GRAY_LEVEL_TWO_TIME           8'h01
`define RST_EVEN_GRAY_LEVEL_ONE_TIME           8'h00
`define RST_SLEEP           1'b0
`define RST_DRIVE_CTRL      4'h0

`define SLEEP_BIT           0

`define ADDR_CMD_PORT       12'h400
`define ADDR_STATUS         12'h404
`define ADDR_DRIVE_CTRL     12'h408
`define ADDR_LUT_READBACK   12'h40c

`define DRV_STEPUP_BIT      0
`define DRV_COLUMN_BIT      1
`define DRV_ROW_BIT         2
`define DRV_EXT_BIT         3

`define STS_SLEEP_BIT       0
`define STS_RESET_BUSY_BIT  1
`define STS_OSC_BIT         2
`define STS_GRAY_BUSY_BIT   3

`define CORE_CLK_MHZ        200
`define SOFT_RESET_TIME_NS  200
`define SOFT_RESET_CYCLES   ((`SOFT_RESET_TIME_NS * `CORE_CLK_MHZ) / 1000)

`endif

// ### design/gray_pkg.sv
package gray_pkg;

   typedef logic [7:0] duration_t;

   typedef struct packed {
      logic [7:0] code;
      logic [7:0] data;
   } cmd_word_s;

   typedef enum logic [1:0] {
      APB_IDLE = 2'b00,
      APB_WAIT = 2'b01,
      APB_DONE = 2'b10
   } apb_state_e;

endpackage

// ### design/gray_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gray_timer_if;
   import gray_pkg::*;
   logic      start;
   logic      clear;
   logic      tick;
   duration_t duration;
   logic      busy;
   logic      done;

   modport ctrl  (output start, clear, tick, duration, input busy, done);
   modport timer (input start, clear, tick, duration, output busy, done);
endinterface
`default_nettype wire

// ### design/gray_level_timer.sv
`timescale 1ns/1ps
`default_nettype none
module gray_level_timer (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   gray_timer_if.timer      tif
);
   import gray_pkg::*;

   duration_t remaining;

   // a load of v runs through v+1 ticks before done
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         remaining <= 8'h00;
         tif.busy  <= 1'b0;
         tif.done  <= 1'b0;
      end else begin
         tif.done <= 1'b0;
         if (tif.clear) begin
            tif.busy <= 1'b0;
         end else if (tif.start && !tif.busy) begin
            remaining <= tif.duration;
            tif.busy  <= 1'b1;
         end else if (tif.busy && tif.tick) begin
            if (remaining == 8'h00) begin
               tif.busy <= 1'b0;
               tif.done <= 1'b1;
            end else begin
               remaining <= remaining - 8'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### design/soft_reset_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "gray_defines.svh"
module soft_reset_seq #(
   parameter int CYCLES = `SOFT_RESET_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic nrst,
   input  wire logic start,
   output var  logic clear,
   output var  logic busy
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] count;

   // busy window never longer than the 200 ns budget
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         count <= '0;
         busy  <= 1'b0;
         clear <= 1'b0;
      end else begin
         clear <= start && !busy;
         if (start && !busy) begin
            count <= CW'(CYCLES - 1);
            busy  <= 1'b1;
         end else if (busy) begin
            if (count == '0) begin
               busy <= 1'b0;
            end else begin
               count <= count - CW'(1);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### design/gray_lut_sleep_reset_cmds.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gray_defines.svh"
module gray_lut_sleep_reset_cmds #(
   parameter int SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES
) (
   input  wire logic              core_clk,
   input  wire logic              nrst,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   // commands for other decoders
   output var  logic              fwd_cmd_valid,
   output var  logic [15:0]       fwd_cmd_word,
   // gray level timing
   input  wire logic              gray_clk,
   input  wire logic              gray_level_start,
   input  wire logic [1:0]        gray_level_sel,
   output var  logic              gray_level_busy,
   output var  logic              gray_level_done,
   output var  gray_pkg::duration_t first_level_duration,
   output var  gray_pkg::duration_t second_level_duration,
   output var  gray_pkg::duration_t third_level_duration,
   output var  logic              gray_clk_output,
   // power and driver control
   output var  logic              sleep_mode,
   output var  logic              osc_enable,
   output var  logic              stepup_enable,
   output var  logic              column_drive_enable,
   output var  logic              row_drive_enable,
   output var  logic              soft_reset_busy,
   // external driver controls from the timing generator
   input  wire logic              frame_sync_in,
   input  wire logic              line_sync_in,
   input  wire logic              row_control_a_in,
   input  wire logic              row_control_b_in,
   input  wire logic              row_serial_in,
   output var  logic              frame_sync_output,
   output var  logic              line_sync_output,
   output var  logic              row_control_a,
   output var  logic              row_control_b,
   output var  logic              row_serial_output
);
   import gray_pkg::*;

   localparam int LUT_ENTRIES = 3;

   apb_state_e          apb_state;
   apb_state_e          next_apb_state;
   logic                apb_fire;
   logic                wr_fire;
   logic                cmd_valid;
   cmd_word_s           cmd;
   logic                addr_is_code;
   logic                addr_known;
   logic                ours;
   duration_t           lut [LUT_ENTRIES];
   logic                sleep_bit;
   logic [3:0]          drive_ctrl;
   logic                soft_start;
   logic                soft_clear;
   logic                soft_busy;
   logic                gray_clk_q;
   duration_t           sel_duration;
   logic [31:0]         next_prdata;
   logic                next_pslverr;

   gray_timer_if        tif ();

   // ---------------------------------------------------------------
   // apb slave: pready rises one edge into the access phase, held
   // off while a software reset is settling
   // ---------------------------------------------------------------
   always_comb begin
      next_apb_state = apb_state;
      unique case (apb_state)
         APB_IDLE: begin
            if (psel && !penable) begin
               next_apb_state = APB_WAIT;
            end
         end
         APB_WAIT: begin
            if (psel && penable && !soft_busy) begin
               next_apb_state = APB_DONE;
            end
         end
         APB_DONE: begin
            next_apb_state = APB_IDLE;
         end
         default: begin
            next_apb_state = APB_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         apb_state <= APB_IDLE;
      end else begin
         apb_state <= next_apb_state;
      end
   end

   assign apb_fire = psel && penable && pready;
   assign wr_fire  = apb_fire && pwrite;

   // word-aligned indices 00h..ffh map straight onto command codes
   assign addr_is_code = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
   assign addr_known   = addr_is_code
                      || (paddr == `ADDR_CMD_PORT)
                      || (paddr == `ADDR_STATUS)
                      || (paddr == `ADDR_DRIVE_CTRL)
                      || (paddr == `ADDR_LUT_READBACK);

   // both entry points end up as one 16-bit command word
   always_comb begin
      cmd       = '0;
      cmd_valid = 1'b0;
      if (wr_fire && paddr == `ADDR_CMD_PORT) begin
         cmd.code  = pwdata[`CMD_CODE_MSB:`CMD_CODE_LSB];
         cmd.data  = pwdata[`CMD_DATA_MSB:`CMD_DATA_LSB];
         cmd_valid = 1'b1;
      end else if (wr_fire && addr_is_code) begin
         cmd.code  = paddr[9:2];
         cmd.data  = pwdata[`CMD_DATA_MSB:`CMD_DATA_LSB];
         cmd_valid = 1'b1;
      end
   end

   assign ours = (cmd.code == `CMD_EVEN_GRAY_LEVEL_ONE_TIME) || (cmd.code == `CMD_EVEN_GRAY_LEVEL_TWO_TIME)
              || (cmd.code == `CMD_EVEN_GRAY_LEVEL_THREE_TIME) || (cmd.code == `CMD_SLEEP)
              || (cmd.code == `CMD_SOFT_RESET);

   always_comb begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = !addr_known;
      if (pwrite) begin
         if (paddr == `ADDR_STATUS || paddr == `ADDR_LUT_READBACK) begin
            next_pslverr = 1'b1;
         end
      end else begin
         unique case (paddr)
            `ADDR_STATUS: begin
               next_prdata[`STS_SLEEP_BIT]      = sleep_bit;
               next_prdata[`STS_RESET_BUSY_BIT] = soft_busy;
               next_prdata[`STS_OSC_BIT]        = !sleep_bit;
               next_prdata[`STS_GRAY_BUSY_BIT]  = tif.busy;
            end
            `ADDR_DRIVE_CTRL: begin
               next_prdata[3:0] = drive_ctrl;
            end
            `ADDR_LUT_READBACK: begin
               next_prdata[23:0] = {lut[2], lut[1], lut[0]};
            end
            default: begin
               // command registers are write-only and read as zero
               next_prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= (next_apb_state == APB_DONE);
         pslverr <= (next_apb_state == APB_DONE) && next_pslverr;
         if (next_apb_state == APB_DONE) begin
            prdata <= next_prdata;
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ---------------------------------------------------------------
   // even gray level table, entry 0 is the first level
   // ---------------------------------------------------------------
   for (genvar g = 0; g < LUT_ENTRIES; g++) begin : g_lut
      localparam logic [7:0] CODE = (g == 0) ? `CMD_EVEN_GRAY_LEVEL_ONE_TIME :
                                    (g == 1) ? `CMD_EVEN_GRAY_LEVEL_TWO_TIME : `CMD_EVEN_GRAY_LEVEL_THREE_TIME;
      localparam logic [7:0] INIT = (g == 0) ? `RST_EVEN_GRAY_LEVEL_ONE_TIME :
                                    (g == 1) ? `RST_EVEN_GRAY_LEVEL_TWO_TIME : `RST_EVEN_GRAY_LEVEL_THREE_TIME;
      // mode restrictions on these loads are the host's to honour
      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            lut[g] <= INIT;
         end else if (soft_clear) begin
            lut[g] <= INIT;
         end else if (cmd_valid && cmd.code == CODE) begin
            lut[g] <= cmd.data;
         end
      end
   end

   // ---------------------------------------------------------------
   // sleep select
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sleep_bit <= `RST_SLEEP;
      end else if (soft_clear) begin
         sleep_bit <= `RST_SLEEP;
      end else if (cmd_valid && cmd.code == `CMD_SLEEP) begin
         sleep_bit <= cmd.data[`SLEEP_BIT];
      end
   end

   // ---------------------------------------------------------------
   // driver enables; only software sets them after a reset
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         drive_ctrl <= `RST_DRIVE_CTRL;
      end else if (soft_clear) begin
         drive_ctrl <= `RST_DRIVE_CTRL;
      end else if (wr_fire && paddr == `ADDR_DRIVE_CTRL) begin
         drive_ctrl <= pwdata[3:0];
      end
   end

   // ---------------------------------------------------------------
   // software reset; data operand deliberately not looked at
   // ---------------------------------------------------------------
   assign soft_start = cmd_valid && (cmd.code == `CMD_SOFT_RESET);

   soft_reset_seq #(
      .CYCLES (SOFT_RESET_CYCLES)
   ) u_soft_reset (
      .core_clk (core_clk),
      .nrst     (nrst),
      .start    (soft_start),
      .clear    (soft_clear),
      .busy     (soft_busy)
   );

   // ---------------------------------------------------------------
   // foreign commands go on untouched
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fwd_cmd_valid <= 1'b0;
         fwd_cmd_word  <= 16'h0000;
      end else begin
         fwd_cmd_valid <= cmd_valid && !ours;
         if (cmd_valid && !ours) begin
            fwd_cmd_word <= cmd;
         end
      end
   end

   // ---------------------------------------------------------------
   // gray level timer, ticks on rising edges of the gray clock
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         gray_clk_q <= 1'b0;
      end else begin
         gray_clk_q <= gray_clk;
      end
   end

   // an out-of-range select falls back to the first level
   always_comb begin
      unique case (gray_level_sel)
         2'b01:   sel_duration = lut[1];
         2'b10:   sel_duration = lut[2];
         default: sel_duration = lut[0];
      endcase
   end

   assign tif.start    = gray_level_start && !sleep_bit;
   assign tif.clear    = soft_clear;
   assign tif.tick     = gray_clk && !gray_clk_q;
   assign tif.duration = sel_duration;

   gray_level_timer u_timer (
      .core_clk (core_clk),
      .nrst     (nrst),
      .tif      (tif)
   );

   assign gray_level_busy       = tif.busy;
   assign gray_level_done       = tif.done;
   assign first_level_duration  = lut[0];
   assign second_level_duration = lut[1];
   assign third_level_duration  = lut[2];
   assign sleep_mode            = sleep_bit;
   assign soft_reset_busy       = soft_busy;

   // ---------------------------------------------------------------
   // pin-facing outputs, all registered
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         osc_enable          <= 1'b1;
         stepup_enable       <= 1'b0;
         column_drive_enable <= 1'b0;
         row_drive_enable    <= 1'b0;
      end else begin
         // oscillator kept alive through reset so commands land in time
         osc_enable          <= !sleep_bit || soft_busy;
         stepup_enable       <= drive_ctrl[`DRV_STEPUP_BIT] && !soft_busy;
         column_drive_enable <= drive_ctrl[`DRV_COLUMN_BIT] && !soft_busy;
         row_drive_enable    <= drive_ctrl[`DRV_ROW_BIT] && !soft_busy;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         gray_clk_output   <= 1'b0;
         frame_sync_output <= 1'b0;
         line_sync_output  <= 1'b0;
         row_control_a     <= 1'b0;
         row_control_b     <= 1'b0;
         row_serial_output <= 1'b0;
      end else begin
         gray_clk_output   <= gray_clk;
         frame_sync_output <= drive_ctrl[`DRV_EXT_BIT] && frame_sync_in;
         line_sync_output  <= drive_ctrl[`DRV_EXT_BIT] && line_sync_in;
         row_control_a     <= drive_ctrl[`DRV_EXT_BIT] && row_control_a_in;
         row_control_b     <= drive_ctrl[`DRV_EXT_BIT] && row_control_b_in;
         row_serial_output <= drive_ctrl[`DRV_EXT_BIT] && row_serial_in;
      end
   end

endmodule
`default_nettype wire

// ### dv/timing_gen_model.sv
`timescale 1ns/1ps
`default_nettype none
module timing_gen_model (
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       slow,
   input  wire logic       sync_high,
   output var  logic       gray_clk,
   output var  logic [4:0] sync
);
   logic [2:0] div;

   // sync keeps moving unless forced high
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         div <= 3'h0;
         gray_clk <= 1'b0;
         sync <= 5'h0;
      end else begin
         div <= div + 3'h1;
         gray_clk <= slow ? div[2] : div[1];
         sync <= sync_high ? 5'h1f : {sync[3:0], ~sync[4]};
      end
   end
endmodule
`default_nettype wire

// ### dv/gray_cmds_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gray_cmds_chk #(
   parameter int SOFT_RESET_CYCLES = 40
) (
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        fwd_cmd_valid,
   input wire logic [15:0] fwd_cmd_word,
   input wire logic        gray_clk,
   input wire logic [7:0]  first_level_duration,
   input wire logic [7:0]  second_level_duration,
   input wire logic [7:0]  third_level_duration,
   input wire logic        gray_clk_output,
   input wire logic        sleep_mode,
   input wire logic        osc_enable,
   input wire logic        stepup_enable,
   input wire logic        column_drive_enable,
   input wire logic        row_drive_enable,
   input wire logic        soft_reset_busy,
   input wire logic        frame_sync_output,
   input wire logic        line_sync_output,
   input wire logic        row_control_a,
   input wire logic        row_control_b,
   input wire logic        row_serial_output
);
   import gray_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic [7:0] code;
   logic       cmt;
   int         bcnt;
   assign code = paddr[10] ? pwdata[15:8] : paddr[9:2];
   assign cmt = psel & penable & pready & pwrite & !pslverr
              & (paddr == 12'h400 | paddr[11:10] == 2'b00);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bcnt <= 0;
      end else begin
         bcnt <= soft_reset_busy ? bcnt + 1 : 0;
      end
   end

   property p_load3;
      cmt && code == 8'h3a |=> third_level_duration == $past(pwdata[7:0]);
   endproperty
   a_load3: assert property (p_load3) else $error("third entry not loaded");
   property p_load2;
      cmt && code == 8'h3b |=> second_level_duration == $past(pwdata[7:0]);
   endproperty
   a_load2: assert property (p_load2) else $error("second entry not loaded");
   property p_load1;
      cmt && code == 8'h3c |=> first_level_duration == $past(pwdata[7:0]);
   endproperty
   a_load1: assert property (p_load1) else $error("first entry not loaded");
   property p_sleep;
      cmt && code == 8'hf1 |=> sleep_mode == $past(pwdata[0]);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep bit wrong");
   property p_srst_go;
      cmt && code == 8'hf2 |-> ##[1:3] soft_reset_busy;
   endproperty
   a_srst_go: assert property (p_srst_go) else $error("soft reset not started");
   property p_srst_dflt;
      $rose(soft_reset_busy) |=> third_level_duration == 8'h02
         && second_level_duration == 8'h01 && first_level_duration == 8'h00 && !sleep_mode;
   endproperty
   a_srst_dflt: assert property (p_srst_dflt) else $error("defaults not restored");
   property p_srst_len;
      $fell(soft_reset_busy) |-> bcnt == SOFT_RESET_CYCLES;
   endproperty
   a_srst_len: assert property (p_srst_len) else $error("settle length wrong");
   property p_srst_drv;
      soft_reset_busy && $past(soft_reset_busy) |-> osc_enable && !stepup_enable
         && !column_drive_enable
         && !row_drive_enable;
   endproperty
   a_srst_drv: assert property (p_srst_drv) else $error("drivers not parked");
   property p_ext_low;
      soft_reset_busy && $past(soft_reset_busy, 2) |-> !(frame_sync_output | line_sync_output
         | row_control_a | row_control_b | row_serial_output);
   endproperty
   a_ext_low: assert property (p_ext_low) else $error("ext outputs not low");
   property p_sclk;
      gray_clk_output == $past(gray_clk);
   endproperty
   a_sclk: assert property (p_sclk) else $error("gray clock not followed");
   property p_fwd;
      cmt && paddr == 12'h400 && !(code inside {8'h3a, 8'h3b, 8'h3c, 8'hf1, 8'hf2})
         |=> fwd_cmd_valid && fwd_cmd_word == $past(pwdata[15:0])
         && $stable(third_level_duration);
   endproperty
   a_fwd: assert property (p_fwd) else $error("foreign cmd wrong");
   c_srst: cover property (soft_reset_busy ##1 !soft_reset_busy);
   c_fwd: cover property (fwd_cmd_valid);
   c_sleep: cover property ($rose(sleep_mode));
endmodule
bind gray_lut_sleep_reset_cmds gray_cmds_chk #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) u_chk (.*);
`default_nettype wire

// ### dv/tb_gray_lut_sleep_reset_cmds.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module tb_gray_lut_sleep_reset_cmds;
   import gray_pkg::*;
   localparam int SRC = 4;
   logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr, err, pg;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, lfsr;
   logic        fwd_cmd_valid, gray_clk, gray_level_start, gray_level_busy, gray_level_done;
   logic [15:0] fwd_cmd_word, fwd_last;
   logic [1:0]  gray_level_sel;
   duration_t   first_level_duration, second_level_duration, third_level_duration, v;
   logic        gray_clk_output, sleep_mode, osc_enable, stepup_enable, column_drive_enable;
   logic        row_drive_enable, soft_reset_busy, slow, sync_high;
   logic        frame_sync_output, line_sync_output, row_control_a, row_control_b;
   logic        row_serial_output;
   logic [4:0]  sync;
   logic [7:0]  exp_t [3];
   logic [7:0]  foreign [4];
   int          fails, n_compared, n, k, rises, nfwd;

   gray_lut_sleep_reset_cmds #(.SOFT_RESET_CYCLES(SRC)) u_dut (
      .*, .frame_sync_in(sync[4]), .line_sync_in(sync[3]), .row_control_a_in(sync[2]),
      .row_control_b_in(sync[1]), .row_serial_in(sync[0]));
   timing_gen_model u_tgen (.*);

   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
   endfunction
   function automatic logic [7:0] code_of(input int i);
      return 8'h3c - 8'(i);
   endfunction
   function automatic logic [23:0] lut_word();
      return {exp_t[2], exp_t[1], exp_t[0]};
   endfunction

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // idle edge after keeps psel edges clean
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int w = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         w++;
      end while (pready !== 1'b1 && w < 200);
      rd = prdata;
      err = pslverr;
      if (w >= 200) begin
         fails++;
         stop_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   always @(negedge core_clk) begin
      if (fwd_cmd_valid === 1'b1) begin
         nfwd++;
         fwd_last = fwd_cmd_word;
      end
   end

   initial begin
      nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      gray_level_start = 0; gray_level_sel = 0; slow = 0; sync_high = 0;
      lfsr = 32'hdc479f99; fails = 0; n_compared = 0; nfwd = 0;
      exp_t = '{8'h00, 8'h01, 8'h02};
      foreign = '{8'h39, 8'h3d, 8'hf0, 8'hf3};
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      apb(0, 12'h40c, 0);
      `CHK(rd[23:0], lut_word())
      apb(0, 12'h404, 0);
      `CHK(rd[2:0], 3'b100)
      $display("test defaults done");
      // no 64-level or monochrome mode here
      for (int i = 0; i < 12; i++) begin
         lfsr = next_rand(lfsr);
         n = lfsr[9:8] % 3;
         exp_t[n] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : lfsr[7:0];
         apb(1, lfsr[10] ? 12'h400 : {2'b00, code_of(n), 2'b00},
             {lfsr[31:16], code_of(n), exp_t[n]});
         `CHK({third_level_duration, second_level_duration, first_level_duration}, lut_word())
      end
      apb(0, 12'h40c, 0);
      `CHK(rd[23:0], lut_word())
      $display("test table loads done");
      for (int i = 0; i < 5; i++) begin
         lfsr = next_rand(lfsr);
         apb(1, i[0] ? 12'h3c4 : 12'h400, {16'h0, 8'hf1, lfsr[7:1], i < 4 && lfsr[0]});
         `CHK(sleep_mode, i < 4 && lfsr[0])
         @(posedge core_clk);
         `CHK(osc_enable, !(i < 4 && lfsr[0]))
      end
      $display("test sleep done");
      for (int i = 0; i < 4; i++) begin
         lfsr = next_rand(lfsr);
         n = nfwd;
         apb(1, 12'h400, {lfsr[31:16], foreign[i], lfsr[7:0]});
         `CHK(nfwd, n + 1)
         `CHK(fwd_last, {foreign[i], lfsr[7:0]})
         `CHK({third_level_duration, second_level_duration, first_level_duration}, lut_word())
      end
      apb(0, 12'h800, 0);
      `CHK(err, 1'b1)
      apb(1, 12'h404, 32'hff);
      `CHK(err, 1'b1)
      $display("test forward and errors done");
      for (int i = 0; i < 3; i++) begin
         lfsr = next_rand(lfsr);
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : lfsr[7:0];
         apb(1, 12'h400, {16'h0, code_of(i), v});
         slow <= (i == 2);
         gray_level_sel <= 2'(i);
         gray_level_start <= 1'b1;
         @(posedge core_clk);
         gray_level_start <= 1'b0;
         pg = gray_clk;
         k = 0;
         rises = 0;
         do begin
            @(posedge core_clk);
            k++;
            rises += (gray_clk && !pg) ? 1 : 0;
            pg = gray_clk;
         end while (gray_level_done !== 1'b1 && k < 5000);
         `CHK(rises, int'(v) + 1)
      end
      $display("test gray timing done");
      apb(1, 12'h408, 32'hf);
      sync_high <= 1'b1;
      apb(1, 12'h3c4, 32'h1);
      repeat (3) @(posedge core_clk);
      `CHK({frame_sync_output, line_sync_output, row_control_a, row_control_b, row_serial_output}, 5'h1f)
      lfsr = next_rand(lfsr);
      apb(1, 12'h400, {lfsr[31:16], 8'hf2, lfsr[7:0]});
      k = 0;
      while (soft_reset_busy !== 1'b1 && k < 10) begin
         @(posedge core_clk);
         k++;
      end
      n = 0;
      while (soft_reset_busy === 1'b1 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      `CHK(n, SRC)
      exp_t = '{8'h00, 8'h01, 8'h02};
      `CHK({third_level_duration, second_level_duration, first_level_duration}, lut_word())
      `CHK({sleep_mode, osc_enable, stepup_enable, column_drive_enable, row_drive_enable}, 5'b01000)
      `CHK({frame_sync_output, line_sync_output, row_control_a, row_control_b, row_serial_output}, 5'h00)
      apb(0, 12'h408, 0);
      `CHK(rd[3:0], 4'h0)
      $display("test soft reset done");
      stop_test();
   end
endmodule
`default_nettype wire
